// ### rtl/camera_dma_burst_config.sv
// Camera write DMA for the format-conversion port: burst configuration registers,
// byte packing, a word FIFO and a burst writer toward the system bus arbiter.
// Assumes an AXI4-Lite master for registers and an arbiter that grants one burst per request.
`timescale 1ns/1ps
`include "cam_dma_map.svh"
module camera_dma_burst_config (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic frame_start_i,
    input wire logic [7:0] pix_data_i,
    input wire logic [1:0] pix_plane_i,
    input wire logic pix_valid_i,
    output logic pix_ready_o,
    input wire logic [31:0] cb_base_i,
    input wire logic [31:0] cr_base_i,
    output logic mem_req_o,
    output logic [31:0] mem_addr_o,
    output logic [15:0] mem_len_o,
    input wire logic mem_ack_i,
    output logic [31:0] mem_wdata_o,
    output logic mem_wvalid_o,
    input wire logic mem_wready_i,
    output logic [31:0] port_a_cb_burst_len_o,
    output logic [31:0] port_a_cr_burst_len_o
);
    cam_dma_pkg::cfg_type cfg, next_cfg;
    logic aw_got, next_aw_got, w_got, next_w_got;
    logic [31:0] aw_addr, next_aw_addr, w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic do_write, hit;
    logic [1:0] byte_idx, next_byte_idx, pack_plane, next_pack_plane;
    logic [23:0] pack_buf, next_pack_buf;
    logic next_pix_ready, pix_take, push;
    cam_dma_pkg::fifo_word_type push_word, head_word;
    logic fifo_in_ready, fifo_valid, pop;
    logic [`FIFO_LEVEL_W-1:0] fifo_level;
    cam_dma_pkg::wr_state_type state, next_state;
    logic [1:0] frame_idx, next_frame_idx, line_plane, next_line_plane;
    logic [31:0] plane_ptr [3];
    logic [31:0] next_plane_ptr [3];
    logic [15:0] words_left, next_words_left, load_left, next_load_left, ack_left, next_ack_left;
    logic next_mem_req, next_mem_wvalid;
    logic [31:0] next_mem_addr, next_mem_wdata;
    logic [15:0] next_mem_len, blen;
    cam_dma_pkg::burst_type pb;

    // Byte-lane merge of a register write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) res[i*8 +: 8] = val[i*8 +: 8];
        end
        return res;
    endfunction : merge

    // Bursts of these lengths exist on the system bus
    function automatic logic supported(input logic [15:0] len);
        return len == 16'h0004 || len == 16'h0008 || len == 16'h0010;
    endfunction : supported

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write and read channels with the register file
    always_comb begin
        next_aw_got = aw_got;
        next_w_got = w_got;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid && !s_axi_bready;
        next_bresp = s_axi_bresp;
        next_cfg = cfg;
        hit = 1'b1;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_got = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_got = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        do_write = aw_got && w_got && !s_axi_bvalid;
        if (do_write) begin
            if (aw_addr == `ADDR_A_CB_BURST) begin
                next_cfg.a_cb = merge(cfg.a_cb, w_data, w_strb);
            end else if (aw_addr == `ADDR_A_CR_BURST) begin
                next_cfg.a_cr = merge(cfg.a_cr, w_data, w_strb);
            end else if (aw_addr == `ADDR_B_SIZE) begin
                {next_cfg.width, next_cfg.height} = 20'(merge({12'h000, cfg.width, cfg.height},
                    w_data, w_strb));
            end else if (aw_addr == `ADDR_B_LUMA_BASE_1) begin
                next_cfg.luma_base[0] = merge(cfg.luma_base[0], w_data, w_strb);
            end else if (aw_addr == `ADDR_B_LUMA_BASE_2) begin
                next_cfg.luma_base[1] = merge(cfg.luma_base[1], w_data, w_strb);
            end else if (aw_addr == `ADDR_B_LUMA_BASE_3) begin
                next_cfg.luma_base[2] = merge(cfg.luma_base[2], w_data, w_strb);
            end else if (aw_addr == `ADDR_B_LUMA_BASE_4) begin
                next_cfg.luma_base[3] = merge(cfg.luma_base[3], w_data, w_strb);
            end else if (aw_addr == `ADDR_B_LUMA_BURST) begin
                next_cfg.b_y = merge(cfg.b_y, w_data, w_strb);
            end else if (aw_addr == `ADDR_B_CB_BURST) begin
                next_cfg.b_cb = merge(cfg.b_cb, w_data, w_strb);
            end else if (aw_addr == `ADDR_B_CR_BURST) begin
                next_cfg.b_cr = merge(cfg.b_cr, w_data, w_strb);
            end else if (aw_addr == `ADDR_CTRL) begin
                if (w_strb[0]) next_cfg.enable = w_data[`CTRL_ENABLE_BIT];
            end else begin
                hit = 1'b0;
            end
            next_aw_got = 1'b0;
            next_w_got = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = hit ? `RESP_OKAY : `RESP_SLVERR;
        end
        next_awready = !next_aw_got && !next_bvalid;
        next_wready = !next_w_got && !next_bvalid;
    end

    // Read side: one read in flight, answer one cycle after the address is taken
    always_comb begin
        next_rvalid = s_axi_rvalid && !s_axi_rready;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = `RESP_OKAY;
            if (s_axi_araddr == `ADDR_A_CB_BURST) next_rdata = cfg.a_cb;
            else if (s_axi_araddr == `ADDR_A_CR_BURST) next_rdata = cfg.a_cr;
            else if (s_axi_araddr == `ADDR_B_SIZE) next_rdata = {12'h000, cfg.width, cfg.height};
            else if (s_axi_araddr == `ADDR_B_LUMA_BASE_1) next_rdata = cfg.luma_base[0];
            else if (s_axi_araddr == `ADDR_B_LUMA_BASE_2) next_rdata = cfg.luma_base[1];
            else if (s_axi_araddr == `ADDR_B_LUMA_BASE_3) next_rdata = cfg.luma_base[2];
            else if (s_axi_araddr == `ADDR_B_LUMA_BASE_4) next_rdata = cfg.luma_base[3];
            else if (s_axi_araddr == `ADDR_B_LUMA_BURST) next_rdata = cfg.b_y;
            else if (s_axi_araddr == `ADDR_B_CB_BURST) next_rdata = cfg.b_cb;
            else if (s_axi_araddr == `ADDR_B_CR_BURST) next_rdata = cfg.b_cr;
            else if (s_axi_araddr == `ADDR_CTRL) next_rdata = {31'h00000000, cfg.enable};
            else if (s_axi_araddr == `ADDR_STATUS) begin
                next_rdata = {19'h0, fifo_level, 2'h0, 2'(state), frame_idx, 2'h0};
            end else begin
                next_rdata = 32'h00000000;
                next_rresp = `RESP_SLVERR;
            end
        end
        next_arready = !next_rvalid;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            cfg.a_cb <= `RST_BURST;
            cfg.a_cr <= `RST_BURST;
            cfg.width <= `RST_WIDTH;
            cfg.height <= `RST_HEIGHT;
            cfg.luma_base[0] <= `RST_LUMA_BASE_1;
            cfg.luma_base[1] <= `RST_LUMA_BASE_2;
            cfg.luma_base[2] <= `RST_LUMA_BASE_3;
            cfg.luma_base[3] <= `RST_LUMA_BASE_4;
            cfg.b_y <= `RST_BURST;
            cfg.b_cb <= `RST_BURST;
            cfg.b_cr <= `RST_BURST;
            cfg.enable <= 1'b0;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= 32'h00000000;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end else begin
            cfg <= next_cfg;
            aw_got <= next_aw_got;
            w_got <= next_w_got;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end

    assign port_a_cb_burst_len_o = cfg.a_cb;
    assign port_a_cr_burst_len_o = cfg.a_cr;

    ////////////////////////////////////////////////////////////////////////
    // Byte packer: four samples per word, first sample in the low byte
    always_comb begin
        pix_take = pix_valid_i && pix_ready_o;
        next_byte_idx = byte_idx;
        next_pack_buf = pack_buf;
        next_pack_plane = pack_plane;
        push = 1'b0;
        push_word.plane = pack_plane;
        push_word.data = {pix_data_i, pack_buf};
        if (pix_take) begin
            next_byte_idx = byte_idx + 2'h1;
            if (byte_idx == 2'h0) next_pack_plane = pix_plane_i;
            if (byte_idx == 2'h3) push = 1'b1;
            else next_pack_buf = {pix_data_i, pack_buf[23:8]};
        end
        // Ready only with room left for a word pushed before the next update
        next_pix_ready = cfg.enable && fifo_in_ready && fifo_level <= `FIFO_LEVEL_W'(`FIFO_DEPTH - 2);
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            byte_idx <= 2'h0;
            pack_buf <= 24'h000000;
            pack_plane <= `PLANE_Y;
            pix_ready_o <= 1'b0;
        end else begin
            byte_idx <= next_byte_idx;
            pack_buf <= next_pack_buf;
            pack_plane <= next_pack_plane;
            pix_ready_o <= next_pix_ready;
        end
    end

    // Word FIFO between the packer and the bus writer
    sync_fifo #(.WIDTH(34), .DEPTH(`FIFO_DEPTH), .LW(`FIFO_LEVEL_W)) i_sync_fifo (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .in_valid_i(push),
        .in_data_i(push_word),
        .in_ready_o(fifo_in_ready),
        .out_valid_o(fifo_valid),
        .out_data_o(head_word),
        .out_ready_i(pop),
        .level_o(fifo_level)
    );

    ////////////////////////////////////////////////////////////////////////
    // Burst writer: line split into main and remainder bursts per plane
    always_comb begin
        next_state = state;
        next_frame_idx = frame_idx;
        next_line_plane = line_plane;
        next_plane_ptr = plane_ptr;
        next_words_left = words_left;
        next_load_left = load_left;
        next_ack_left = ack_left;
        next_mem_req = mem_req_o;
        next_mem_addr = mem_addr_o;
        next_mem_len = mem_len_o;
        next_mem_wdata = mem_wdata_o;
        pb = (line_plane == `PLANE_Y) ? cfg.b_y : (line_plane == `PLANE_CB) ? cfg.b_cb : cfg.b_cr;
        // main bursts while more than the remainder is left
        if (words_left > pb.tail_len) begin
            blen = (pb.main_len == 16'h0000) ? 16'h0001 : pb.main_len;
            if (blen > words_left) blen = words_left;
        end else begin
            blen = supported(words_left) ? words_left : 16'h0001;
        end
        pop = state == cam_dma_pkg::WR_DATA && load_left != 16'h0000 && fifo_valid
            && (!mem_wvalid_o || mem_wready_i);
        next_mem_wvalid = pop ? 1'b1 : (mem_wready_i ? 1'b0 : mem_wvalid_o);
        if (pop) begin
            next_mem_wdata = head_word.data;
            next_load_left = load_left - 16'h0001;
        end
        case (state)
            cam_dma_pkg::WR_IDLE: begin
                if (frame_start_i) begin
                    // rotate to the next of the four luma memories and rewind plane pointers
                    next_plane_ptr[0] = cfg.luma_base[frame_idx];
                    next_plane_ptr[1] = cb_base_i;
                    next_plane_ptr[2] = cr_base_i;
                    next_frame_idx = frame_idx + 2'h1;
                    next_words_left = 16'h0000;
                end else if (words_left != 16'h0000) begin
                    next_state = cam_dma_pkg::WR_REQ;
                    next_mem_req = 1'b1;
                    next_mem_addr = plane_ptr[line_plane];
                    next_mem_len = blen;
                    next_load_left = blen;
                    next_ack_left = blen;
                end else if (fifo_valid) begin
                    next_line_plane = head_word.plane;
                    next_words_left = (head_word.plane == `PLANE_Y) ? 16'(cfg.width[9:2])
                        : 16'(cfg.width[9:3]);
                end
            end
            cam_dma_pkg::WR_REQ: begin
                if (mem_ack_i) begin
                    next_mem_req = 1'b0;
                    next_state = cam_dma_pkg::WR_DATA;
                end
            end
            cam_dma_pkg::WR_DATA: begin
                if (mem_wvalid_o && mem_wready_i) begin
                    next_plane_ptr[line_plane] = plane_ptr[line_plane] + `BYTES_PER_WORD;
                    next_words_left = words_left - 16'h0001;
                    next_ack_left = ack_left - 16'h0001;
                    if (ack_left == 16'h0001) next_state = cam_dma_pkg::WR_IDLE;
                end
            end
            default: next_state = cam_dma_pkg::WR_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            state <= cam_dma_pkg::WR_IDLE;
            frame_idx <= 2'h0;
            line_plane <= `PLANE_Y;
            plane_ptr[0] <= `RST_LUMA_BASE_1;
            plane_ptr[1] <= 32'h00000000;
            plane_ptr[2] <= 32'h00000000;
            words_left <= 16'h0000;
            load_left <= 16'h0000;
            ack_left <= 16'h0000;
            mem_req_o <= 1'b0;
            mem_addr_o <= 32'h00000000;
            mem_len_o <= 16'h0000;
            mem_wdata_o <= 32'h00000000;
            mem_wvalid_o <= 1'b0;
        end else begin
            state <= next_state;
            frame_idx <= next_frame_idx;
            line_plane <= next_line_plane;
            plane_ptr <= next_plane_ptr;
            words_left <= next_words_left;
            load_left <= next_load_left;
            ack_left <= next_ack_left;
            mem_req_o <= next_mem_req;
            mem_addr_o <= next_mem_addr;
            mem_len_o <= next_mem_len;
            mem_wdata_o <= next_mem_wdata;
            mem_wvalid_o <= next_mem_wvalid;
        end
    end
endmodule : camera_dma_burst_config

// ### rtl/cam_dma_map.svh
// Register map, field positions, reset values and fixed sizes of the camera write DMA
// Assumes inclusion by the main module and the testbench; the guard keeps one copy
`ifndef CAM_DMA_MAP_SVH
`define CAM_DMA_MAP_SVH
`define ADDR_A_CB_BURST 32'h4f000018
`define ADDR_A_CR_BURST 32'h4f00001c
`define ADDR_B_SIZE 32'h4f000020
`define ADDR_B_LUMA_BASE_1 32'h4f000024
`define ADDR_B_LUMA_BASE_2 32'h4f000028
`define ADDR_B_LUMA_BASE_3 32'h4f00002c
`define ADDR_B_LUMA_BASE_4 32'h4f000030
`define ADDR_B_LUMA_BURST 32'h4f000034
`define ADDR_B_CB_BURST 32'h4f000038
`define ADDR_B_CR_BURST 32'h4f00003c
`define ADDR_CTRL 32'h4f000058
`define ADDR_STATUS 32'h4f000060
`define RST_BURST 32'h00000000
`define RST_WIDTH 10'h320
`define RST_HEIGHT 10'h258
`define RST_LUMA_BASE_1 32'hc073f000
`define RST_LUMA_BASE_2 32'hc07eec80
`define RST_LUMA_BASE_3 32'hc089e900
`define RST_LUMA_BASE_4 32'hc094e580
`define RST_CTRL 32'h00000000
`define SIZE_WIDTH_LSB 10
`define SIZE_HEIGHT_LSB 0
`define CTRL_ENABLE_BIT 0
`define PLANE_Y 2'h0
`define PLANE_CB 2'h1
`define PLANE_CR 2'h2
`define FIFO_DEPTH 16
`define FIFO_LEVEL_W 5
`define BYTES_PER_WORD 32'h00000004
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ### rtl/cam_dma_pkg.sv
// Types shared by the camera write DMA and its data FIFO
// Assumes the map header for numbers; holds types only
package cam_dma_pkg;
    typedef struct packed {
        logic [15:0] main_len;
        logic [15:0] tail_len;
    } burst_type;
    typedef struct packed {
        logic [1:0] plane;
        logic [31:0] data;
    } fifo_word_type;
    typedef struct packed {
        burst_type a_cb;
        burst_type a_cr;
        logic [9:0] width;
        logic [9:0] height;
        logic [3:0][31:0] luma_base;
        burst_type b_y;
        burst_type b_cb;
        burst_type b_cr;
        logic enable;
    } cfg_type;
    typedef enum logic [1:0] {WR_IDLE, WR_REQ, WR_DATA} wr_state_type;
endpackage : cam_dma_pkg

// ### rtl/sync_fifo.sv
// Synchronous FIFO with valid and ready on both sides and a fill level
// Assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module sync_fifo #(
    parameter int WIDTH = 34,
    parameter int DEPTH = 16,
    parameter int LW = 5
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i,
    output logic [LW-1:0] level_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [LW-1:0] level, next_level;
    logic push, pop;

    ////////////////////////////////////////////////////////////////////////
    // Handshakes and pointer updates
    always_comb begin
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        next_wr_ptr = push ? wr_ptr + AW'(1) : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + AW'(1) : rd_ptr;
        next_level = level + LW'(push) - LW'(pop);
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            level <= next_level;
        end
    end

    // Storage has no reset; only written words are ever read
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    assign in_ready_o = level != LW'(DEPTH);
    assign out_valid_o = level != '0;
    assign out_data_o = mem[rd_ptr];
    assign level_o = level;
endmodule : sync_fifo

// ### sim/cam_mem_model.sv
// Memory-side model of the arbiter and system bus slave
// Assumes the writer holds a request until granted
`timescale 1ns/1ps
module cam_mem_model (
    input wire logic clk_i,
    input wire logic req_i,
    input wire logic [31:0] addr_i,
    input wire logic [15:0] len_i,
    output logic ack_o,
    input wire logic [31:0] wdata_i,
    input wire logic wvalid_i,
    output logic wready_o
);
    logic [31:0] addrs[$];
    logic [15:0] lens[$];
    logic [31:0] words[$];
    int wait_n = 0;
    initial begin
        ack_o = 1'b0;
        wready_o = 1'b0;
    end
    // Grant after three cycles, stall every other beat, log all traffic
    always @(posedge clk_i) begin
        ack_o <= 1'b0;
        wready_o <= ~wready_o;
        if (wvalid_i && wready_o) words.push_back(wdata_i);
        if (req_i && !ack_o) begin
            wait_n <= (wait_n == 2) ? 0 : wait_n + 1;
            if (wait_n == 2) begin
                ack_o <= 1'b1;
                addrs.push_back(addr_i);
                lens.push_back(len_i);
            end
        end
    end
endmodule : cam_mem_model

// ### sim/cam_dma_chk.sv
// Port checker for the camera write DMA
// Assumes a bind onto camera_dma_burst_config
`timescale 1ns/1ps
module cam_dma_chk (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic mem_req_o,
    input wire logic [31:0] mem_addr_o,
    input wire logic [15:0] mem_len_o,
    input wire logic mem_ack_i,
    input wire logic [31:0] mem_wdata_o,
    input wire logic mem_wvalid_o,
    input wire logic mem_wready_i
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    ////////////////////////////////////////////////////////////////
    AST_REQ_HOLD: assert property (mem_req_o && !mem_ack_i |=>
        mem_req_o && $stable(mem_addr_o) && $stable(mem_len_o))
        else $error("burst request changed before grant");
    AST_ACK_DROP: assert property (mem_req_o && mem_ack_i |=> !mem_req_o)
        else $error("request stayed after grant");
    AST_LEN: assert property (mem_req_o |-> mem_len_o != 16'h0000)
        else $error("zero burst length");
    AST_ALIGN: assert property (mem_req_o |-> mem_addr_o[1:0] == 2'h0)
        else $error("unaligned burst address");
    AST_BEAT_HOLD: assert property (mem_wvalid_o && !mem_wready_i |=> mem_wvalid_o && $stable(mem_wdata_o))
        else $error("beat changed before accept");
    AST_RLAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_RCLR: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    AST_BCLR: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
endmodule : cam_dma_chk

// ### sim/camera_dma_burst_config_tb.sv
// Testbench for the camera write DMA: registers, byte stream and bursts
// Assumes the memory model on the writer side
`timescale 1ns/1ps
`include "cam_dma_map.svh"
module camera_dma_burst_config_tb;
    logic clk_i = 1'b0, rst_b_i = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, frame_start = 1'b0, pix_valid = 1'b0;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, mem_addr, mem_wdata, a_cb, a_cr;
    logic [7:0] pix_data = 8'h00;
    logic [1:0] bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid, pix_ready, mem_req, mem_ack, mem_wvalid, mem_wready;
    logic [15:0] mem_len;
    int num_errors = 0, num_checks = 0;
    // Free-running 100 MHz clock
    always #5 clk_i = ~clk_i;
    camera_dma_burst_config i_camera_dma_burst_config (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .frame_start_i(frame_start), .pix_data_i(pix_data), .pix_plane_i(2'h0),
        .pix_valid_i(pix_valid), .pix_ready_o(pix_ready), .cb_base_i(32'h0), .cr_base_i(32'h0),
        .mem_req_o(mem_req), .mem_addr_o(mem_addr), .mem_len_o(mem_len), .mem_ack_i(mem_ack),
        .mem_wdata_o(mem_wdata), .mem_wvalid_o(mem_wvalid), .mem_wready_i(mem_wready),
        .port_a_cb_burst_len_o(a_cb), .port_a_cr_burst_len_o(a_cr));
    cam_mem_model i_mem_model (.clk_i(clk_i), .req_i(mem_req), .addr_i(mem_addr), .len_i(mem_len),
        .ack_o(mem_ack), .wdata_i(mem_wdata), .wvalid_i(mem_wvalid), .wready_o(mem_wready));
    ////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] e);
        @(posedge clk_i);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk_i);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk(bresp, e);
    endtask : wr
    task rd(input logic [31:0] a, input logic [31:0] d, input logic [1:0] e);
        @(posedge clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk_i);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        chk(rdata, d);
        chk(rresp, e);
    endtask : rd
    task t_reset;
        logic [31:0] v;
        for (int i = 0; i < 10; i++) begin
            v = (i == 2) ? 32'h000c8258 : (i == 3) ? 32'hc073f000 : (i == 4) ? 32'hc07eec80 :
                (i == 5) ? 32'hc089e900 : (i == 6) ? 32'hc094e580 : 32'h00000000;
            rd(32'h4f000018 + 32'(4 * i), v, 2'h0);
        end
        $display("test reset values done");
    endtask : t_reset
    task t_regs;
        wr(`ADDR_A_CB_BURST, 32'h00100004, 2'h0);
        wr(`ADDR_A_CR_BURST, 32'h00040002, 2'h0);
        wr(`ADDR_B_SIZE, 32'hfff0a001, 2'h0);
        chk(a_cb, 32'h00100004);
        chk(a_cr, 32'h00040002);
        rd(`ADDR_B_SIZE, 32'h0000a001, 2'h0);
        wr(`ADDR_B_LUMA_BASE_4, 32'h12345678, 2'h0);
        rd(`ADDR_B_LUMA_BASE_4, 32'h12345678, 2'h0);
        wr(32'h4f000004, 32'h00000001, 2'h2);
        rd(32'h4f000004, 32'h00000000, 2'h2);
        wr(`ADDR_B_LUMA_BURST, 32'h00080008, 2'h0);
        rd(`ADDR_B_LUMA_BURST, 32'h00080008, 2'h0);
        wr(`ADDR_B_CB_BURST, 32'h00040004, 2'h0);
        wr(`ADDR_B_CR_BURST, 32'h00040004, 2'h0);
        rd(`ADDR_B_CB_BURST, 32'h00040004, 2'h0);
        rd(`ADDR_B_CR_BURST, 32'h00040004, 2'h0);
        $display("test register access done");
    endtask : t_regs
    task t_stream;
        logic [31:0] w;
        wr(`ADDR_B_LUMA_BURST, 32'h00040002, 2'h0);
        wr(`ADDR_CTRL, 32'h00000001, 2'h0);
        @(posedge clk_i);
        frame_start <= 1'b1;
        @(posedge clk_i);
        frame_start <= 1'b0;
        for (int k = 0; k < 40; k++) begin
            pix_data <= 8'(k);
            pix_valid <= 1'b1;
            do @(posedge clk_i); while (!pix_ready);
        end
        pix_valid <= 1'b0;
        for (int n = 0; n < 300 && i_mem_model.words.size() < 10; n++) @(posedge clk_i);
        chk(i_mem_model.lens.size(), 32'h4);
        for (int b = 0; b < 4; b++) begin
            chk(i_mem_model.lens[b], (b < 2) ? 32'h4 : 32'h1);
            chk(i_mem_model.addrs[b], 32'hc073f000 + 32'((b < 2) ? 16 * b : 24 + 4 * b));
        end
        for (int i = 0; i < 10; i++) begin
            w = {8'(4 * i + 3), 8'(4 * i + 2), 8'(4 * i + 1), 8'(4 * i)};
            chk(i_mem_model.words[i], w);
        end
        rd(`ADDR_STATUS, 32'h00000004, 2'h0);
        $display("test stream bursts done");
    endtask : t_stream
    task give_verdict;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : give_verdict
    // Main sequence after 20 cycles of reset
    initial begin
        repeat (20) @(posedge clk_i);
        rst_b_i <= 1'b1;
        t_reset;
        t_regs;
        t_stream;
        give_verdict;
    end
    // Watchdog well beyond the expected run
    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        give_verdict;
    end
endmodule : camera_dma_burst_config_tb
bind camera_dma_burst_config cam_dma_chk i_chk (.*);
